/* File: rtl/spc_serial_port.v */
// serial port control flags: control register, tx and rx shifters
// assumes an axi4-lite master on mclk_i, timer overflow pulse on same clock
//
// Summary of operation
// R01: mode bits select sync or async framing
// R02: every control bit clears on reset
// R03: multiproc enable, async only: flag only if ninth bit (stop bit in mode 1) is one
// R04: receive enable gates the receiver
// R05: nine-bit modes send tx_ninth_bit
// R06: nine-bit modes store received ninth bit
// R07: eight-bit async stores stop bit
// R08: tx done at eighth bit or stop
// R09: sync rx done after eighth bit
// R10: async rx done mid stop bit
// R11: fixed mode 64 or 32 clocks per bit
// R12: flags cleared by software only
`include "spc_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module spc_serial_port (
    input wire mclk_i,
    input wire rst_i,
    input wire baud_double_i,
    input wire timer_ovf_i,
    input wire rxd_i,
    output wire rxd_o,
    output wire rxd_oe_o,
    output wire txd_o,
    output wire serial_irq_o,
    input wire [3:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [3:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i
);
////////////////////////////////////////////////////////////////////////////
// states, one-hot
localparam ST_IDLE = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_WAIT = 3'h4;

reg [7:0] ctrl_r; // control register
reg [7:0] rxbuf_r; // receive buffer
reg rx_s1_r; // synchroniser first stage
reg rx_s2_r; // synchroniser second stage
reg rx_d_r; // previous synchronised level, for start edge
reg bd_s1_r; // baud doubling pin, first stage
reg bd_s2_r; // baud doubling pin, second stage

// bus slave state
reg aw_got_r;
reg w_got_r;
reg [3:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
reg bvalid_r;
reg [1:0] bresp_r;
reg rvalid_r;
reg [31:0] rdata_r;
reg [1:0] rresp_r;

wire [1:0] mode = {ctrl_r[`SPC_B_MSH], ctrl_r[`SPC_B_MSL]}; // [R01]
wire nine_bit = mode[1]; // modes 2 and 3 carry a ninth bit

////////////////////////////////////////////////////////////////////////////
// bit timing: one tick per bit, chosen by mode
reg [6:0] tx_div_r;
reg [6:0] rx_div_r;
reg [6:0] per;
reg [3:0] nbits;
always @* begin
    case (mode)
        `SPC_MODE_SYNC: per = `SPC_CLK_SYNC;
        // [R11] doubling halves the bit time
        `SPC_MODE_A9F: per = bd_s2_r ? `SPC_CLK_FAST : `SPC_CLK_SLOW;
        default: per = `SPC_CLK_FAST; // timer modes: count ovf pulses
    endcase
    case (mode)
        `SPC_MODE_SYNC: nbits = `SPC_BITS_SYNC - 4'h1; // [R08] last bit
        `SPC_MODE_A8: nbits = `SPC_BITS_8;
        default: nbits = `SPC_BITS_9;
    endcase
end
// timer modes advance the divider only on overflow, else every clock
wire div_step = (mode == `SPC_MODE_A8 || mode == `SPC_MODE_A9T) ?
    timer_ovf_i : 1'b1; // [R01]

////////////////////////////////////////////////////////////////////////////
// bus decode
wire wr_go = aw_got_r && w_got_r && !bvalid_r;
wire wr_ctrl = wr_go && awaddr_r == `SPC_OFS_CTRL && wstrb_r[0];
wire wr_tx = wr_go && awaddr_r == `SPC_OFS_TXD && wstrb_r[0];
wire wr_ok = awaddr_r == `SPC_OFS_CTRL || awaddr_r == `SPC_OFS_TXD;
assign s_axi_awready_o = !aw_got_r && !bvalid_r;
assign s_axi_wready_o = !w_got_r && !bvalid_r;
assign s_axi_bvalid_o = bvalid_r;
assign s_axi_bresp_o = bresp_r;
assign s_axi_arready_o = !rvalid_r;
assign s_axi_rvalid_o = rvalid_r;
assign s_axi_rdata_o = rdata_r;
assign s_axi_rresp_o = rresp_r;

// write channel capture and response
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awaddr_r <= 4'h0;
        wdata_r <= 32'h0000_0000;
        wstrb_r <= 4'h0;
        bvalid_r <= 1'b0;
        bresp_r <= `SPC_RESP_OK;
    end else begin
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
        end
        if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? `SPC_RESP_OK : `SPC_RESP_SLVERR;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
        end else if (bvalid_r && s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end
end

// read channel; reading rx data has no side effect here
wire [3:0] ra = s_axi_araddr_i;
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        rvalid_r <= 1'b0;
        rdata_r <= 32'h0000_0000;
        rresp_r <= `SPC_RESP_OK;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
        rvalid_r <= 1'b1;
        rresp_r <= `SPC_RESP_OK;
        if (ra == `SPC_OFS_CTRL) begin
            rdata_r <= {24'h000000, ctrl_r};
        end else if (ra == `SPC_OFS_RXD) begin
            rdata_r <= {24'h000000, rxbuf_r};
        end else begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= (ra == `SPC_OFS_TXD) ? `SPC_RESP_OK :
                `SPC_RESP_SLVERR;
        end
    end else if (rvalid_r && s_axi_rready_i) begin
        rvalid_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// transmitter: async frame is start, data lsb first, ninth bit in modes 2 and 3, stop; sync sends data only
reg [2:0] tx_st_r;
reg [10:0] tx_sh_r; // frame bits still to send
reg [3:0] tx_cnt_r;
reg txd_r;
reg shclk_r;
wire tx_tick = div_step && tx_div_r == per - 7'h01;
wire tx_end = tx_st_r == ST_RUN && tx_tick && tx_cnt_r == nbits;
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        tx_st_r <= ST_IDLE;
        tx_sh_r <= 11'h7FF;
        tx_cnt_r <= 4'h0;
        tx_div_r <= 7'h00;
        txd_r <= 1'b1;
        shclk_r <= 1'b1;
    end else begin
        case (tx_st_r)
            ST_IDLE: begin
                tx_div_r <= 7'h00;
                if (wr_tx) begin
                    tx_cnt_r <= 4'h0;
                    tx_st_r <= ST_RUN;
                    if (mode == `SPC_MODE_SYNC) begin
                        tx_sh_r <= {3'h7, wdata_r[7:0]};
                    end else begin
                        // [R05] ninth bit from control in 9-bit modes
                        tx_sh_r <= {1'b1, nine_bit ? ctrl_r[`SPC_B_TX9] :
                            1'b1, wdata_r[7:0], 1'b0};
                    end
                end
            end
            ST_RUN: begin
                tx_div_r <= tx_tick ? 7'h00 :
                    (div_step ? tx_div_r + 7'h01 : tx_div_r);
                // shift clock low for first half of each sync bit
                shclk_r <= (mode != `SPC_MODE_SYNC) ||
                    (tx_div_r >= (per >> 1));
                if (tx_div_r == 7'h00 && div_step) begin
                    txd_r <= tx_sh_r[0];
                end
                if (tx_tick) begin
                    tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                    tx_cnt_r <= tx_cnt_r + 4'h1;
                    if (tx_end) begin
                        tx_st_r <= ST_IDLE;
                    end
                end
            end
            default: tx_st_r <= ST_IDLE;
        endcase
        if (tx_st_r == ST_IDLE) begin
            txd_r <= 1'b1;
            shclk_r <= 1'b1;
        end
    end
end
// sync mode: data on rxd pin, shift clock on txd pin only while transmitting
wire sync_tx = mode == `SPC_MODE_SYNC && tx_st_r == ST_RUN;
assign rxd_o = txd_r;
assign rxd_oe_o = sync_tx;
assign txd_o = (mode == `SPC_MODE_SYNC) ? shclk_r : txd_r;

////////////////////////////////////////////////////////////////////////////
// receiver; two-flop sync on the pin
reg [2:0] rx_st_r;
reg [8:0] rx_sh_r; // data plus ninth bit in nine-bit modes
reg [3:0] rx_cnt_r;
wire rx_en = ctrl_r[`SPC_B_REN]; // [R04]
wire rx_tick = div_step && rx_div_r == per - 7'h01;
wire rx_mid = div_step && rx_div_r == (per >> 1);
wire rx_done_sync = rx_st_r == ST_RUN && mode == `SPC_MODE_SYNC &&
    rx_tick && rx_cnt_r == `SPC_BITS_SYNC - 4'h1; // [R09]
wire rx_done_async = rx_st_r == ST_RUN && mode != `SPC_MODE_SYNC &&
    rx_mid && rx_cnt_r == nbits; // [R10] mid stop bit
// captured stop or ninth bit, value at mid stop
wire rx_last = nine_bit ? rx_sh_r[8] : rx_s2_r;
wire rx_keep = !ctrl_r[`SPC_B_MPE] || rx_last; // [R03]
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        rx_s1_r <= 1'b1;
        rx_s2_r <= 1'b1;
        rx_d_r <= 1'b1;
        bd_s1_r <= 1'b0;
        bd_s2_r <= 1'b0;
        rx_st_r <= ST_IDLE;
        rx_sh_r <= 9'h000;
        rx_cnt_r <= 4'h0;
        rx_div_r <= 7'h00;
    end else begin
        rx_s1_r <= rxd_i;
        rx_s2_r <= rx_s1_r;
        rx_d_r <= rx_s2_r;
        bd_s1_r <= baud_double_i;
        bd_s2_r <= bd_s1_r;
        case (rx_st_r)
            ST_IDLE: begin
                rx_div_r <= 7'h00;
                rx_cnt_r <= 4'h0;
                // [R04] sync rx starts when enabled, flag clear and transmitter idle
                if (rx_en && mode == `SPC_MODE_SYNC &&
                        !ctrl_r[`SPC_B_RXDONE] && tx_st_r == ST_IDLE) begin
                    rx_st_r <= ST_RUN;
                end else if (rx_en && mode != `SPC_MODE_SYNC &&
                        rx_d_r && !rx_s2_r) begin
                    rx_st_r <= ST_RUN; // start edge
                end
            end
            ST_RUN: begin
                rx_div_r <= rx_tick ? 7'h00 :
                    (div_step ? rx_div_r + 7'h01 : rx_div_r);
                if (!rx_en) begin
                    rx_st_r <= ST_IDLE;
                end else if (mode == `SPC_MODE_SYNC && rx_tick) begin
                    rx_sh_r <= {1'b0, rx_s2_r, rx_sh_r[7:1]};
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                    if (rx_done_sync) begin
                        rx_st_r <= ST_WAIT;
                    end
                end else if (mode != `SPC_MODE_SYNC && rx_mid) begin
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                    if (rx_cnt_r == 4'h0 && rx_s2_r) begin
                        rx_st_r <= ST_IDLE; // false start
                    end else if (rx_done_async) begin
                        rx_st_r <= ST_IDLE;
                    end else if (rx_cnt_r != 4'h0) begin
                        rx_sh_r <= nine_bit ? {rx_s2_r, rx_sh_r[8:1]} :
                            {1'b0, rx_s2_r, rx_sh_r[7:1]};
                    end
                end
            end
            ST_WAIT: begin
                // hold until software clears the done flag
                if (!ctrl_r[`SPC_B_RXDONE]) begin
                    rx_st_r <= ST_IDLE;
                end
            end
            default: rx_st_r <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// control register: software write, hardware sets win over clear
wire rx_word = rx_done_sync || (rx_done_async && rx_keep);
always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
        ctrl_r <= `SPC_CTRL_RST; // [R02]
        rxbuf_r <= 8'h00;
    end else begin
        if (wr_ctrl) begin
            ctrl_r <= wdata_r[7:0];
        end
        if (tx_end) begin
            ctrl_r[`SPC_B_TXDONE] <= 1'b1; // [R08] [R12]
        end
        if (rx_word) begin
            ctrl_r[`SPC_B_RXDONE] <= 1'b1; // [R03] [R12]
            rxbuf_r <= rx_done_sync ? {rx_s2_r, rx_sh_r[7:1]} : rx_sh_r[7:0];
            if (rx_done_async) begin
                // [R06] ninth bit, [R07] stop bit in 8-bit mode
                ctrl_r[`SPC_B_RX9] <= rx_last;
            end
        end
    end
end
assign serial_irq_o = ctrl_r[`SPC_B_TXDONE] | ctrl_r[`SPC_B_RXDONE];
endmodule
`default_nettype wire

/* File: rtl/spc_defines.vh */
// constants for the serial port control flag block
// assumes inclusion by bare name from rtl files
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH
// register byte offsets on the axi4-lite bus
`define SPC_OFS_CTRL 4'h0
`define SPC_OFS_TXD 4'h4
`define SPC_OFS_RXD 4'h8
// control register bit positions
`define SPC_B_MSH 7
`define SPC_B_MSL 6
`define SPC_B_MPE 5
`define SPC_B_REN 4
`define SPC_B_TX9 3
`define SPC_B_RX9 2
`define SPC_B_TXDONE 1
`define SPC_B_RXDONE 0
`define SPC_CTRL_RST 8'h00
// mode codes
`define SPC_MODE_SYNC 2'h0
`define SPC_MODE_A8 2'h1
`define SPC_MODE_A9F 2'h2
`define SPC_MODE_A9T 2'h3
// timing: oscillator clocks per bit, or overflow pulses per bit in timer modes
`define SPC_CLK_SYNC 7'h0C
`define SPC_CLK_SLOW 7'h40
`define SPC_CLK_FAST 7'h20
// frame bit counts
`define SPC_BITS_SYNC 4'h8
`define SPC_BITS_8 4'h9
`define SPC_BITS_9 4'hA
// axi responses
`define SPC_RESP_OK 2'h0
`define SPC_RESP_SLVERR 2'h2
`endif

/* File: test/spc_peer.sv */
// remote serial peer: sends async frames, captures the device's frames
// assumes lsb-first frames on lines that idle high
`timescale 1ns/10ps
`default_nettype none
module spc_peer (
    input wire logic mclk_i,
    input wire logic line_i,
    output logic line_o
);
    // mark level between frames
    initial line_o = 1'b1;
    ////////////////////////////////////////////////////////////////////
    // one frame, bit zero first, then back to mark
    task send(input logic [10:0] f, input int n, input int clks);
        for (int i = 0; i < n; i++) begin
            line_o <= f[i];
            repeat (clks) @(posedge mclk_i);
        end
        line_o <= 1'b1;
    endtask
    // wait for start, sample mid-bit; late entry costs a few cycles only
    task catch_frame(input int n, input int clks, output logic [10:0] f,
        output logic ok);
        int w;
        w = 0;
        f = 11'h7FF;
        while (line_i !== 1'b0 && w < 4000) begin
            @(posedge mclk_i);
            w++;
        end
        ok = (w < 4000);
        repeat (clks / 2) @(posedge mclk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = line_i;
            repeat (clks) @(posedge mclk_i);
        end
    endtask
endmodule
`default_nettype wire

/* File: test/spc_serial_port_checker.sv */
// checker for bus handshakes and flag behaviour at the block's ports
// assumes one clock domain, bound onto spc_serial_port
`timescale 1ns/10ps
`default_nettype none
module spc_serial_port_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic txd_o,
    input wire logic serial_irq_o,
    input wire logic s_axi_awready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////
    property p_b_stand;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
    endproperty
    a_b_stand: assert property (p_b_stand) else $error("bvalid dropped");
    property p_r_stand;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o;
    endproperty
    a_r_stand: assert property (p_r_stand) else $error("rvalid dropped");
    property p_r_data;
        s_axi_rvalid_o && !s_axi_rready_i |=> $stable(s_axi_rdata_o);
    endproperty
    a_r_data: assert property (p_r_data) else $error("rdata moved");
    property p_ar_block;
        s_axi_rvalid_o |-> !s_axi_arready_o;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("arready early");
    property p_aw_block;
        s_axi_bvalid_o |-> !s_axi_awready_o;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("awready early");
    property p_bresp_code;
        s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0 || s_axi_bresp_o == 2'h2;
    endproperty
    a_bresp_code: assert property (p_bresp_code) else $error("bad bresp");
    // line idle and no pending flag right after reset
    property p_reset_idle;
        $fell(rst_i) |-> txd_o && !serial_irq_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle");
    // flags only fall with a software write completing
    property p_irq_clear;
        $fell(serial_irq_o) |-> $rose(s_axi_bvalid_o);
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("flag lost");
endmodule
bind spc_serial_port spc_serial_port_checker chk_u (.*);
`default_nettype wire

/* File: test/spc_serial_port_bench.sv */
// bench for the serial port control block: bus tasks plus peer frames
// assumes spc_peer on the serial lines and timer pulses every other cycle
`timescale 1ns/10ps
`default_nettype none
module spc_serial_port_bench;
    logic mclk_i = 1'b0, rst_i = 1'b1, bd = 1'b1, tov = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    wire logic rxd, txd, irq, awready, wready, bvalid, arready, rvalid;
    wire logic sdo, sdo_oe;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int miscompares = 0, checks_done = 0;
    always #2 mclk_i = ~mclk_i;
    // overflow every second clock: timer modes run 64 clocks per bit
    always @(posedge mclk_i) tov <= ~tov;
    spc_peer peer_u (.mclk_i(mclk_i), .line_i(txd), .line_o(rxd));
    spc_serial_port dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .baud_double_i(bd), .timer_ovf_i(tov), .rxd_i(rxd), .rxd_o(sdo),
        .rxd_oe_o(sdo_oe), .txd_o(txd), .serial_irq_o(irq),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready));
    ////////////////////////////////////////////////////////////////////
    task summarize;
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task tmo(input int n);
        if (n >= 2000) begin
            miscompares++;
            $display("BAD %0t bus wait ran out", $time);
            summarize;
        end
    endtask
    // ready is raised late on purpose so the slave must hold its answer
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) bready <= 1'b1;
        end while (!(bvalid === 1'b1 && bready) && n < 2000);
        tmo(n);
        chk({30'h0, bresp}, {30'h0, e});
        bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] e);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) rready <= 1'b1;
        end while (!(rvalid === 1'b1 && rready) && n < 2000);
        tmo(n);
        d = rdata;
        chk({30'h0, rresp}, {30'h0, e});
        rready <= 1'b0;
    endtask
    // send a word, frame must carry the ninth bit, then tx_done raised
    task txcase(input logic [7:0] c, input logic [7:0] d);
        logic [10:0] f;
        logic ok;
        logic [31:0] v;
        wr(4'h0, {24'h0, c}, 2'h0);
        wr(4'h4, {24'h0, d}, 2'h0);
        peer_u.catch_frame(11, c[6] ? 64 : 32, f, ok);
        chk({31'h0, ok}, 32'h1);
        chk({21'h0, f}, {21'h0, 1'b1, c[3], d, 1'b0});
        repeat (40) @(posedge mclk_i);
        rd(4'h0, v, 2'h0);
        chk(v, {24'h0, c | 8'h02});
        chk({31'h0, irq}, 32'h1);
    endtask
    // peer sends a frame; flags and buffer compared with expectation
    task rxcase(input logic [7:0] c, input logic [10:0] f, input int n,
        input int k, input logic [7:0] e);
        logic [31:0] v;
        wr(4'h0, {24'h0, c}, 2'h0);
        peer_u.send(f, n, k);
        repeat (8) @(posedge mclk_i);
        rd(4'h0, v, 2'h0);
        chk(v, {24'h0, e});
        if (e[0]) rd(4'h8, v, 2'h0);
        if (e[0]) chk(v, {24'h0, (c[7:6] == 2'h0) ? f[7:0] : f[8:1]});
    endtask
    // sync transmit: data on rxd_o, taken at each rise of the shift clock
    task synccase(input logic [7:0] d);
        logic [7:0] f;
        logic p, oe;
        logic [31:0] v;
        int n;
        wr(4'h0, 32'h0, 2'h0);
        wr(4'h4, {24'h0, d}, 2'h0);
        n = 0;
        p = 1'b1;
        oe = 1'b1;
        f = 8'h00;
        for (int i = 0; i < 8 && n < 2000; n++) begin
            @(negedge mclk_i);
            if (p === 1'b0 && txd === 1'b1) begin
                f[i] = sdo;
                oe = oe & sdo_oe;
                i++;
            end
            p = txd;
        end
        tmo(n);
        chk({24'h0, f}, {24'h0, d});
        chk({31'h0, oe}, 32'h1);
        // no ninth shift clock may follow the eighth data bit
        n = 0;
        repeat (24) begin
            @(negedge mclk_i);
            if (p === 1'b0 && txd === 1'b1) n++;
            p = txd;
        end
        chk(n, 32'h0);
        @(posedge mclk_i);
        rd(4'h0, v, 2'h0);
        chk(v, 32'h2);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] v;
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(4'h0, v, 2'h0);
        chk(v, 32'h0);
        txcase(8'h98, 8'hA5);
        txcase(8'hC8, 8'h5A);
        synccase(8'h96);
        rxcase(8'h90, {2'h3, 8'h3C, 1'b0}, 11, 32, 8'h95);
        bd <= 1'b0;
        rxcase(8'hB0, {2'h2, 8'h11, 1'b0}, 11, 64, 8'hB0);
        rxcase(8'hB0, {2'h3, 8'h22, 1'b0}, 11, 64, 8'hB5);
        rxcase(8'h80, {2'h3, 8'h33, 1'b0}, 11, 64, 8'h80);
        rxcase(8'h50, {2'h3, 8'h5A, 1'b0}, 10, 64, 8'h55);
        rxcase(8'h10, {3'h0, 8'hC3}, 8, 12, 8'h11);
        rd(4'hC, v, 2'h2);
        chk(v, 32'h0);
        wr(4'hC, 32'hFF, 2'h2);
        summarize;
    end
endmodule
`default_nettype wire
